// [src/rai_pkg.sv]
// Shared register map, field positions and reset values of the alarm block
`default_nettype none
package rai_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_MINUTE_COUNT  = 8'h01;
  localparam logic [7:0] ADDR_HOUR_COUNT    = 8'h02;
  localparam logic [7:0] ADDR_WEEKDAY_COUNT = 8'h03;
  localparam logic [7:0] ADDR_DATE_COUNT    = 8'h04;
  localparam logic [7:0] ADDR_MINUTE_MATCH  = 8'h08;
  localparam logic [7:0] ADDR_HOUR_MATCH    = 8'h09;
  localparam logic [7:0] ADDR_WDAY_DATE     = 8'h0a;
  localparam logic [7:0] ADDR_EXT_CONTROL   = 8'h0d;
  localparam logic [7:0] ADDR_EVENT_FLAGS   = 8'h0e;
  localparam logic [7:0] ADDR_IRQ_CONTROL   = 8'h0f;
  // Field positions
  localparam int MATCH_EXCLUDE_BIT   = 7;
  localparam int WDAY_OR_DATE_BIT    = 6;
  localparam int ALARM_FLAG_BIT      = 3;
  localparam int ALARM_IRQ_EN_BIT    = 3;
  localparam int CTRL_RESET_BIT      = 0;
  // Field masks
  localparam logic [7:0] MINUTE_MASK   = 8'h7f;
  localparam logic [7:0] HOUR_MASK     = 8'h3f;
  localparam logic [7:0] DATE_MASK     = 8'h3f;
  localparam logic [7:0] WEEKDAY_MASK  = 8'h7f;
  localparam logic [7:0] HOUR_RW_MASK  = 8'hff;
  localparam logic [7:0] FLAGS_RW_MASK = 8'h3f;
  localparam logic [7:0] CTRL_RW_MASK  = 8'hfd;
  localparam logic [7:0] COUNT_RD_MASK = 8'h7f;
  // Reset values
  localparam logic [7:0] MATCH_RESET   = 8'h00;
  localparam logic [7:0] EXT_RESET     = 8'h00;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] ZERO_BYTE     = 8'h00;
endpackage
`default_nettype wire

// [src/rai_alarm.sv]
// Alarm match, sticky alarm flag and open-drain interrupt drive
`timescale 1ns/1ps
`default_nettype none
module rai_alarm (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Register access port from the serial interface
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  // Running time counters and their minute update strobe
  input  wire logic [7:0] i_minute,
  input  wire logic [7:0] i_hour,
  input  wire logic [7:0] i_weekday,
  input  wire logic [7:0] i_date,
  input  wire logic       i_minute_tick,
  // Other interrupt sources and their flags
  input  wire logic [7:0] i_other_flags,
  input  wire logic       i_other_int_low,
  // Open-drain interrupt pin, active low
  output logic            o_int_n_out,
  output logic            o_int_oe_n,
  // Alarm status
  output logic            o_alarm_flag,
  output logic            o_ctrl_reset
);

  // Register state
  logic [7:0] minute_match_reg;
  logic [7:0] minute_match_next;
  logic [7:0] hour_match_reg;
  logic [7:0] hour_match_next;
  logic [7:0] wday_date_match_reg;
  logic [7:0] wday_date_match_next;
  logic [7:0] ext_control_reg;
  logic [7:0] ext_control_next;
  logic [7:0] irq_control_reg;
  logic [7:0] irq_control_next;
  logic       alarm_flag_reg;
  logic       alarm_flag_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       alarm_match;
  logic       alarm_event;
  logic       flag_clear;
  logic       alarm_irq_enable;
  logic       weekday_or_date_select;
  logic       alarm_drive;

  // Masked equality of one BCD field, used for minute, hour and date
  function automatic logic field_eq(input logic [7:0] a,
                                    input logic [7:0] b,
                                    input logic [7:0] mask);
    field_eq = ((a & mask) == (b & mask));
  endfunction

  // Write strobe decode for one register offset
  function automatic logic wr_hit(input logic       en,
                                  input logic [7:0] addr,
                                  input logic [7:0] target);
    wr_hit = en && (addr == target);
  endfunction

  assign alarm_irq_enable       = irq_control_reg[rai_pkg::ALARM_IRQ_EN_BIT];
  assign weekday_or_date_select = ext_control_reg[rai_pkg::WDAY_OR_DATE_BIT];

  // Match of the enabled fields against the live counters
  always_comb begin
    logic min_ok;
    logic hour_ok;
    logic day_ok;
    min_ok  = 1'b0;
    hour_ok = 1'b0;
    day_ok  = 1'b0;
    // Excluded register counts as matched
    min_ok  = minute_match_reg[rai_pkg::MATCH_EXCLUDE_BIT] ||
              field_eq(minute_match_reg, i_minute,
                       rai_pkg::MINUTE_MASK);
    hour_ok = hour_match_reg[rai_pkg::MATCH_EXCLUDE_BIT] ||
              field_eq(hour_match_reg, i_hour,
                       rai_pkg::HOUR_MASK);
    if (wday_date_match_reg[rai_pkg::MATCH_EXCLUDE_BIT]) begin
      day_ok = 1'b1;
    end else if (weekday_or_date_select) begin
      day_ok = field_eq(wday_date_match_reg, i_date,
                        rai_pkg::DATE_MASK);
    end else begin
      // Any selected day matches the one-hot weekday counter
      day_ok = |(wday_date_match_reg & i_weekday &
                 rai_pkg::WEEKDAY_MASK);
    end
    alarm_match = min_ok && hour_ok && day_ok;
  end

  // Only the minute strobe samples the match, so a standing match
  // and a freshly programmed present time both wait for the next advance
  assign alarm_event = i_minute_tick && alarm_match &&
    !irq_control_reg[rai_pkg::CTRL_RESET_BIT];

  // A zero written to the flag bit clears it; a one does nothing
  assign flag_clear = wr_hit(i_wr_en, i_addr, rai_pkg::ADDR_EVENT_FLAGS) &&
                      !i_wdata[rai_pkg::ALARM_FLAG_BIT];

  // Next values of the register file and flag
  always_comb begin
    minute_match_next    = minute_match_reg;
    hour_match_next      = hour_match_reg;
    wday_date_match_next = wday_date_match_reg;
    ext_control_next     = ext_control_reg;
    irq_control_next     = irq_control_reg;
    if (wr_hit(i_wr_en, i_addr, rai_pkg::ADDR_MINUTE_MATCH)) begin
      minute_match_next = i_wdata;
    end
    // Bit 6 of hour and date alarms is plain storage
    if (wr_hit(i_wr_en, i_addr, rai_pkg::ADDR_HOUR_MATCH)) begin
      hour_match_next = i_wdata & rai_pkg::HOUR_RW_MASK;
    end
    if (wr_hit(i_wr_en, i_addr, rai_pkg::ADDR_WDAY_DATE)) begin
      wday_date_match_next = i_wdata;
    end
    if (wr_hit(i_wr_en, i_addr, rai_pkg::ADDR_EXT_CONTROL)) begin
      ext_control_next = i_wdata;
    end
    if (wr_hit(i_wr_en, i_addr, rai_pkg::ADDR_IRQ_CONTROL)) begin
      irq_control_next = i_wdata & rai_pkg::CTRL_RW_MASK;
    end
    // Set wins over a clear in the same cycle so no event is lost
    if (alarm_event) begin
      alarm_flag_next = 1'b1;
    end else if (flag_clear) begin
      alarm_flag_next = 1'b0;
    end else begin
      alarm_flag_next = alarm_flag_reg;
    end
  end

  // Read data mux; counters read back live with bit 7 as zero
  always_comb begin
    rdata_next = rdata_reg;
    if (i_rd_en) begin
      unique case (i_addr)
        rai_pkg::ADDR_MINUTE_COUNT:
          rdata_next = i_minute & rai_pkg::COUNT_RD_MASK;
        rai_pkg::ADDR_HOUR_COUNT:
          rdata_next = i_hour & rai_pkg::HOUR_MASK;
        rai_pkg::ADDR_WEEKDAY_COUNT:
          rdata_next = i_weekday & rai_pkg::WEEKDAY_MASK;
        rai_pkg::ADDR_DATE_COUNT:
          rdata_next = i_date & rai_pkg::DATE_MASK;
        rai_pkg::ADDR_MINUTE_MATCH: rdata_next = minute_match_reg;
        rai_pkg::ADDR_HOUR_MATCH:   rdata_next = hour_match_reg;
        rai_pkg::ADDR_WDAY_DATE:    rdata_next = wday_date_match_reg;
        rai_pkg::ADDR_EXT_CONTROL:  rdata_next = ext_control_reg;
        rai_pkg::ADDR_EVENT_FLAGS: begin
          // Top two bits are fixed zero
          rdata_next = i_other_flags & rai_pkg::FLAGS_RW_MASK;
          rdata_next[rai_pkg::ALARM_FLAG_BIT] = alarm_flag_reg;
        end
        rai_pkg::ADDR_IRQ_CONTROL:  rdata_next = irq_control_reg;
        default:                    rdata_next = rai_pkg::ZERO_BYTE;
      endcase
    end
  end

  // State registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      minute_match_reg    <= rai_pkg::MATCH_RESET;
      hour_match_reg      <= rai_pkg::MATCH_RESET;
      wday_date_match_reg <= rai_pkg::MATCH_RESET;
      ext_control_reg     <= rai_pkg::EXT_RESET;
      irq_control_reg     <= rai_pkg::CTRL_RESET;
      alarm_flag_reg      <= 1'b0;
      rdata_reg           <= rai_pkg::ZERO_BYTE;
    end else begin
      minute_match_reg    <= minute_match_next;
      hour_match_reg      <= hour_match_next;
      wday_date_match_reg <= wday_date_match_next;
      ext_control_reg     <= ext_control_next;
      irq_control_reg     <= irq_control_next;
      alarm_flag_reg      <= alarm_flag_next;
      rdata_reg           <= rdata_next;
    end
  end

  // Pin drive follows flag and enable directly, so either clear
  // releases it in the same cycle; no timed auto release for alarms
  assign alarm_drive = alarm_flag_reg &&
                       alarm_irq_enable;
  // Wired-or with the other sources on the shared pin
  assign o_int_oe_n   = !(alarm_drive || i_other_int_low);
  assign o_int_n_out  = 1'b0;
  assign o_rdata      = rdata_reg;
  assign o_alarm_flag = alarm_flag_reg;
  assign o_ctrl_reset = irq_control_reg[rai_pkg::CTRL_RESET_BIT];

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_flag_write_one;
    i_wr_en && i_addr == rai_pkg::ADDR_EVENT_FLAGS &&
      i_wdata[rai_pkg::ALARM_FLAG_BIT];
  endsequence

  // Minute update while software reset is off, the first step of an event
  sequence s_live_tick;
    i_minute_tick && !o_ctrl_reset;
  endsequence

  a_event_sets_flag: assert property (
    alarm_event |=> alarm_flag_reg)
    else $error("alarm event did not set the flag");
  a_flag_stays_set: assert property (
    alarm_flag_reg && !flag_clear |=> alarm_flag_reg)
    else $error("alarm flag dropped without a zero write");
  a_write_one_none: assert property (
    !alarm_flag_reg && !alarm_event ##0 s_flag_write_one |=> !alarm_flag_reg)
    else $error("writing one changed the alarm flag");
  a_pin_low_held: assert property (
    alarm_flag_reg && alarm_irq_enable |-> !o_int_oe_n && !o_int_n_out)
    else $error("pin not driven low while alarm is pending");
  a_enable_release: assert property (
    $fell(alarm_irq_enable) && !i_other_int_low |-> o_int_oe_n)
    else $error("pin held low after the enable was cleared");
  a_flag_release: assert property (
    $fell(alarm_flag_reg) && !i_other_int_low |-> o_int_oe_n)
    else $error("pin held low after the flag was cleared");
  a_disabled_no_pin: assert property (
    alarm_event && !alarm_irq_enable &&
      !irq_control_next[rai_pkg::ALARM_IRQ_EN_BIT] &&
      !i_other_int_low |=> o_int_oe_n && alarm_flag_reg)
    else $error("disabled alarm drove the pin or lost the flag");
  a_reset_bit_blocks: assert property (
    o_ctrl_reset && !alarm_flag_reg |=> !alarm_flag_reg)
    else $error("alarm event while the reset bit is set");
  a_tick_only_event: assert property (
    !i_minute_tick |-> !alarm_event)
    else $error("alarm event without a minute update");
  a_every_minute: assert property (
    minute_match_reg[rai_pkg::MATCH_EXCLUDE_BIT] &&
      hour_match_reg[rai_pkg::MATCH_EXCLUDE_BIT] &&
      wday_date_match_reg[rai_pkg::MATCH_EXCLUDE_BIT] &&
      i_minute_tick && !o_ctrl_reset |=> alarm_flag_reg)
    else $error("all-excluded alarm missed a minute");
  a_fixed_zero_read: assert property (
    $past(i_rd_en) && $past(i_addr) == rai_pkg::ADDR_EVENT_FLAGS
      |-> (o_rdata & ~rai_pkg::FLAGS_RW_MASK) == rai_pkg::ZERO_BYTE)
    else $error("fixed zero flag bits read as one");
  a_ctrl_zero_bits: assert property (
    (irq_control_reg & ~rai_pkg::CTRL_RW_MASK) == rai_pkg::ZERO_BYTE)
    else $error("fixed zero control bit was stored");
  a_flag_clear_works: assert property (
    flag_clear && !alarm_event |=> !alarm_flag_reg)
    else $error("zero write did not clear the alarm flag");
  // Other sources share the pin, so the alarm must never mask them
  a_other_holds_pin: assert property (
    i_other_int_low |-> !o_int_oe_n)
    else $error("pin released while another source holds it");
  a_pin_released_idle: assert property (
    !(alarm_flag_reg && alarm_irq_enable) && !i_other_int_low
      |-> o_int_oe_n)
    else $error("pin driven with no pending enabled alarm");
  a_event_on_match: assert property (
    s_live_tick ##0 alarm_match |=> alarm_flag_reg)
    else $error("matching minute update raised no event");
  // A weekday alarm may pick several days; any one of them is enough
  a_weekday_any: assert property (
    s_live_tick ##0 (!weekday_or_date_select &&
      minute_match_reg[rai_pkg::MATCH_EXCLUDE_BIT] &&
      hour_match_reg[rai_pkg::MATCH_EXCLUDE_BIT] &&
      |(wday_date_match_reg & i_weekday & rai_pkg::WEEKDAY_MASK))
      |=> alarm_flag_reg)
    else $error("selected weekday did not raise the alarm");
  // In date mode the weekday counter must not rescue a date mismatch
  a_date_ignores_day: assert property (
    weekday_or_date_select &&
      !wday_date_match_reg[rai_pkg::MATCH_EXCLUDE_BIT] &&
      !field_eq(wday_date_match_reg, i_date, rai_pkg::DATE_MASK)
      |-> !alarm_event)
    else $error("date alarm fired on a different date");
  // The spare bit 6 of hour and date alarms is kept as written
  a_hour_bit_stored: assert property (
    i_wr_en && i_addr == rai_pkg::ADDR_HOUR_MATCH
      |=> hour_match_reg == $past(i_wdata))
    else $error("hour match byte not stored as written");
  a_date_bit_stored: assert property (
    i_wr_en && i_addr == rai_pkg::ADDR_WDAY_DATE
      |=> wday_date_match_reg == $past(i_wdata))
    else $error("day match byte not stored as written");
endmodule
`default_nettype wire

// [tb/rai_host.sv]
// Host model: register port master and pulled-up interrupt pin
`timescale 1ns/1ps
`default_nettype none
module rai_host (
  // Clock
  input  wire logic       i_clk,
  // Register port toward the alarm block
  output logic            o_wr_en,
  output logic            o_rd_en,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata,
  input  wire logic [7:0] i_rdata,
  // Open-drain pin, pulled up on the board
  input  wire logic       i_int_n_out,
  input  wire logic       i_int_oe_n,
  output logic            o_int_level
);
  // Released pin floats up to the pull-up level
  assign o_int_level = i_int_oe_n ? 1'b1 : i_int_n_out;
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr  = 8'h00;
    o_wdata = 8'h00;
  end
  // Idle bus shows inverted values so a stale address never passes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk) #5;
    o_wr_en = 1'b1;
    o_addr  = a;
    o_wdata = d;
    @(posedge i_clk) #5;
    o_wr_en = 1'b0;
    o_addr  = ~a;
    o_wdata = ~d;
  endtask
  // Read data is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk) #5;
    o_rd_en = 1'b1;
    o_addr  = a;
    @(posedge i_clk) #5;
    o_rd_en = 1'b0;
    o_addr  = ~a;
    d       = i_rdata;
  endtask
endmodule
`default_nettype wire

// [tb/rai_alarm_tb.sv]
// Self-checking bench of the alarm block against an integer model
`timescale 1ns/1ps
`default_nettype none
module rai_alarm_tb;
  logic       clk, rst_n, wr, rdn, tk, oth, ol, oe_n, fl, cr, lvl;
  logic [7:0] ad, wd, rdat, mi, hr, wk, dt, of, r;
  int         fail_count, checks, am, ah, aw, sel, en, rb, flag, d, k;
  rai_alarm rai_alarm_i (.i_clk(clk), .i_rst_n(rst_n), .i_wr_en(wr),
    .i_rd_en(rdn), .i_addr(ad), .i_wdata(wd), .o_rdata(rdat),
    .i_minute(mi), .i_hour(hr), .i_weekday(wk), .i_date(dt),
    .i_minute_tick(tk), .i_other_flags(of), .i_other_int_low(oth),
    .o_int_n_out(ol), .o_int_oe_n(oe_n), .o_alarm_flag(fl),
    .o_ctrl_reset(cr));
  rai_host rai_host_i (.i_clk(clk), .o_wr_en(wr), .o_rd_en(rdn),
    .o_addr(ad), .o_wdata(wd), .i_rdata(rdat), .i_int_n_out(ol),
    .i_int_oe_n(oe_n), .o_int_level(lvl));
  // Clock of 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Model match: excluded fields always agree
  function automatic int mt(int m, int h, int w, int c);
    int dm;
    dm = sel ? ((aw & 8'h3f) == c) : ((aw & w & 8'h7f) != 0);
    return (am >= 128 || (am & 8'h7f) == m) &&
           (ah >= 128 || (ah & 8'h3f) == h) && (aw >= 128 || dm);
  endfunction
  // Flag and resolved pin against the model
  task automatic st();
    chk({7'h00, fl}, 8'(flag));
    chk({7'h00, lvl}, ((flag && en) || oth) ? 8'h00 : 8'h01);
    chk({7'h00, cr}, 8'(rb));
  endtask
  // Register write that also updates the model
  task automatic sr(input logic [7:0] a, input logic [7:0] v);
    rai_host_i.wr(a, v);
    case (a)
      rai_pkg::ADDR_MINUTE_MATCH: am = v;
      rai_pkg::ADDR_HOUR_MATCH:   ah = v;
      rai_pkg::ADDR_WDAY_DATE:    aw = v;
      rai_pkg::ADDR_EXT_CONTROL:  sel = v[6];
      rai_pkg::ADDR_EVENT_FLAGS:  if (!v[3]) flag = 0;
      rai_pkg::ADDR_IRQ_CONTROL: begin
        en = v[3];
        rb = v[0];
      end
      default: ;
    endcase
  endtask
  // One minute advance with the given counter values
  task automatic tick(input int m, input int h, input int w, input int c);
    @(posedge clk) #5;
    {mi, hr, wk, dt} = {8'(m), 8'(h), 8'(w), 8'(c)};
    tk = 1'b1;
    @(posedge clk) #5;
    tk = 1'b0;
    if (mt(m, h, w, c) && !rb) flag = 1;
    st();
  endtask
  task automatic done(input string s);
    $display("Test %s finished, failures so far %0d", s, fail_count);
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the hundred or so cycles the tests need
  initial begin
    #2000000;
    fail_count++;
    conclude();
  end
  initial begin
    {rst_n, tk, oth, mi, hr, wk, dt} = '0;
    {am, ah, aw, sel, en, rb, flag, fail_count, checks} = '0;
    void'($urandom(2));
    of = 8'($urandom);
    repeat (2) @(posedge clk);
    #5 rst_n = 1'b1;
    rai_host_i.rd(rai_pkg::ADDR_IRQ_CONTROL, r);
    chk(r, 8'h00);
    sr(rai_pkg::ADDR_IRQ_CONTROL, 8'hf6);
    rai_host_i.rd(rai_pkg::ADDR_IRQ_CONTROL, r);
    chk(r, 8'hf4);
    sr(rai_pkg::ADDR_IRQ_CONTROL, 8'h00);
    sr(rai_pkg::ADDR_HOUR_MATCH, 8'h7f);
    rai_host_i.rd(rai_pkg::ADDR_HOUR_MATCH, r);
    chk(r, 8'h7f);
    done("registers");
    // Counters already at the alarm time before it is set: no event
    {mi, hr} = {8'h30, 8'h07};
    rai_host_i.rd(rai_pkg::ADDR_MINUTE_COUNT, r);
    chk(r, 8'h30);
    sr(rai_pkg::ADDR_MINUTE_MATCH, 8'h30);
    sr(rai_pkg::ADDR_HOUR_MATCH, 8'h07);
    sr(rai_pkg::ADDR_WDAY_DATE, 8'h80);
    sr(rai_pkg::ADDR_IRQ_CONTROL, 8'h08);
    st();
    tick(8'h30, 8'h07, 1, 1);
    tick(8'h31, 8'h07, 1, 1);
    sr(rai_pkg::ADDR_EVENT_FLAGS, 8'h08);
    st();
    sr(rai_pkg::ADDR_IRQ_CONTROL, 8'h00);
    st();
    sr(rai_pkg::ADDR_IRQ_CONTROL, 8'h08);
    sr(rai_pkg::ADDR_EVENT_FLAGS, 8'h00);
    st();
    sr(rai_pkg::ADDR_EVENT_FLAGS, 8'h08);
    st();
    sr(rai_pkg::ADDR_IRQ_CONTROL, 8'h00);
    tick(8'h30, 8'h07, 1, 1);
    rai_host_i.rd(rai_pkg::ADDR_EVENT_FLAGS, r);
    chk(r, (of & 8'h37) | 8'h08);
    oth = 1'b1;
    @(posedge clk) #5;
    st();
    oth = 1'b0;
    sr(rai_pkg::ADDR_EVENT_FLAGS, 8'h00);
    sr(rai_pkg::ADDR_IRQ_CONTROL, 8'h09);
    tick(8'h30, 8'h07, 1, 1);
    sr(rai_pkg::ADDR_IRQ_CONTROL, 8'h08);
    done("alarm event");
    // Random weekday set, every day tried
    sr(rai_pkg::ADDR_MINUTE_MATCH, 8'h80);
    sr(rai_pkg::ADDR_HOUR_MATCH, 8'h80);
    sr(rai_pkg::ADDR_WDAY_DATE, 8'($urandom) & 8'h7f);
    for (d = 0; d < 7; d++) begin
      sr(rai_pkg::ADDR_EVENT_FLAGS, 8'h00);
      tick(0, 0, 1 << d, 8'h15);
    end
    sr(rai_pkg::ADDR_EXT_CONTROL, 8'h40);
    sr(rai_pkg::ADDR_WDAY_DATE, 8'h15);
    for (d = 0; d < 2; d++) begin
      sr(rai_pkg::ADDR_EVENT_FLAGS, 8'h00);
      tick(0, 0, 8'h7f, 8'h14 + d);
    end
    done("day select");
    sr(rai_pkg::ADDR_WDAY_DATE, 8'h80);
    for (k = 0; k < 3; k++) begin
      sr(rai_pkg::ADDR_EVENT_FLAGS, 8'h00);
      tick($urandom % 60, 8'h12, 1, 1);
    end
    done("every minute");
    // Reset in mid-run returns the block and the model to zero
    rst_n = 1'b0;
    @(posedge clk) #5;
    rst_n = 1'b1;
    {am, ah, aw, sel, en, rb, flag} = '0;
    st();
    rai_host_i.rd(rai_pkg::ADDR_EXT_CONTROL, r);
    chk(r, 8'h00);
    done("mid-run reset");
    conclude();
  end
endmodule
`default_nettype wire
